// ---- akc_byte_editor.sv ----
// Computes the next staged byte from one edit operation.
// Combinational; the composer top registers the result.
`timescale 1ns/1ns
`include "akc_params.svh"

module akc_byte_editor
  import akc_pkg::*;
(
  input akc_op_e op,
  input logic [7:0] wdata,
  input logic [7:0] cur,
  output logic [7:0] nxt
);

  // Bit 1 of the byte sits in the most significant position
  function automatic logic [2:0] bit_pos(input logic [3:0] num);
    logic [3:0] pos;
    pos = `AKC_BIT_LAST - num;
    bit_pos = pos[2:0];
  endfunction : bit_pos

  // Each edit touches only its own field; other bits are kept
  always_comb begin
    nxt = cur;
    case (op)
      OP_WHOLE: nxt = wdata;
      OP_CODE: nxt[`AKC_CODE_MSB:`AKC_CODE_LSB] =
        wdata[`AKC_NODE_MSB:`AKC_NODE_LSB];
      OP_NODE: nxt[`AKC_NODE_MSB:`AKC_NODE_LSB] =
        wdata[`AKC_NODE_MSB:`AKC_NODE_LSB];
      OP_PRESET: begin
        case (wdata[`AKC_PRESET_MSB:0])
          `AKC_SEL_ZEROS: nxt = `AKC_PAT_ZEROS;
          `AKC_SEL_ONES: nxt = `AKC_PAT_ONES;
          `AKC_SEL_ALT: nxt = `AKC_PAT_ALT;
          default: nxt = cur;
        endcase
      end
      OP_BIT: begin
        // Bit numbers outside one to eight are ignored
        if (wdata[3:0] >= `AKC_BIT_FIRST && wdata[3:0] <= `AKC_BIT_LAST)
          nxt[bit_pos(wdata[3:0])] = wdata[`AKC_BITVAL_POS];
      end
      default: nxt = cur;
    endcase
  end

endmodule : akc_byte_editor

// ---- akc_code_table.sv ----
// Interprets the request code of the staged byte under the current mode.
// Purely combinational; fed from registers of the composer top.
`timescale 1ns/1ns
`include "akc_params.svh"

module akc_code_table
  import akc_pkg::*;
(
  input logic mode,
  input logic [3:0] code,
  output akc_req_e kind,
  output logic unused
);

  // Two tables; the stored bits never change, only their meaning
  always_comb begin
    kind = RQ_UNUSED;
    if (mode == `AKC_MODE_RING) begin
      case (code)
        4'h0: kind = RQ_NONE;
        4'h1: kind = RQ_REV_RING;
        4'h2: kind = RQ_REV_SPAN;
        4'h3: kind = RQ_EXER_RING;
        4'h4: kind = RQ_EXER_SPAN;
        4'h5: kind = RQ_RESTORE_WAIT;
        4'h6: kind = RQ_MAN_RING;
        4'h7: kind = RQ_MAN_SPAN;
        4'h8: kind = RQ_DEG_RING;
        4'h9: kind = RQ_DEG_SPAN;
        4'hA: kind = RQ_DEG_PROT;
        4'hB: kind = RQ_FAIL_RING;
        4'hC: kind = RQ_FAIL_SPAN;
        4'hD: kind = RQ_FORCE_RING;
        4'hE: kind = RQ_FORCE_SPAN;
        default: kind = RQ_LOCK_SPAN;
      endcase
    end else begin
      case (code)
        4'h0: kind = RQ_NONE;
        4'h1: kind = RQ_NO_REVERT;
        4'h2: kind = RQ_REVERSE;
        4'h4: kind = RQ_EXER;
        4'h6: kind = RQ_RESTORE_WAIT;
        4'h8: kind = RQ_MANUAL;
        4'hA: kind = RQ_DEG_LO;
        4'hB: kind = RQ_DEG_HI;
        4'hC: kind = RQ_FAIL_LO;
        4'hD: kind = RQ_FAIL_HI;
        4'hE: kind = RQ_FORCE;
        4'hF: kind = RQ_LOCKOUT;
        default: kind = RQ_UNUSED;
      endcase
    end
    unused = (kind == RQ_UNUSED);
  end

endmodule : akc_code_table

// ---- akc_composer.sv ----
// Protection request byte composer: staging, commit and frame insertion.
// Assumes an Avalon-MM master on mclk and an overhead inserter on mclk
// that pulses oh_slot in the request byte position of each frame.
//
// How it works
// - Mode register selects span or ring meaning
// - Committed byte goes out in each frame slot
// - Upper nibble is the request code, per-mode table
// - Ring codes zero to seven as listed
// - Ring codes eight to fifteen as listed
// - Span codes, with three five seven nine unused
// - Span codes ten to fifteen as listed
// - Lower nibble is node or channel by mode
// - Lower nibble accepts any of sixteen values
// - Whole byte: zeros, ones, alternating, arbitrary
// - Any single bit may be set alone
// - Edits stage; only commit changes transmitted byte
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "akc_params.svh"

module akc_composer
  import akc_pkg::*;
(
  input logic mclk,
  input logic arst_n,
  input logic [5:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input logic oh_slot,
  output logic [7:0] oh_k1_data,
  output logic oh_k1_valid,
  output logic [7:0] tx_byte,
  output logic mode_ring
);

  akc_state_s st_r;
  akc_state_s st_nxt;
  akc_op_e op;
  akc_req_e kind;
  logic unused;
  logic wr_ok;
  logic rd_take;
  logic [7:0] stage_edit;
  logic [31:0] rd_word;

  // Address compare, used by the write decode; the read multiplexer cases on the address
  function automatic logic hit(input logic [5:0] addr,
                               input logic [5:0] off);
    hit = (addr == off);
  endfunction : hit

  // A write lands in the cycle the slave shows waitrequest low;
  // lane 0 must be enabled since every field sits in the low byte
  assign wr_ok = avs_write & ~st_r.wait_rq & avs_byteenable[0];

  // Read data are captured while waitrequest is still high
  assign rd_take = avs_read & st_r.wait_rq;

  // Map the accepted write onto an edit of the staged byte
  assign op = !wr_ok ? OP_NONE :
    hit(avs_address, `AKC_OFF_STAGE) ? OP_WHOLE :
    hit(avs_address, `AKC_OFF_CODE) ? OP_CODE :
    hit(avs_address, `AKC_OFF_NODE) ? OP_NODE :
    hit(avs_address, `AKC_OFF_PRESET) ? OP_PRESET :
    hit(avs_address, `AKC_OFF_BIT) ? OP_BIT : OP_NONE;

  // Field and preset edits of the staged copy
  akc_byte_editor u_editor (
    .op(op),
    .wdata(avs_writedata[7:0]),
    .cur(st_r.stage),
    .nxt(stage_edit)
  );

  // Meaning of the staged code under the current mode
  akc_code_table u_table (
    .mode(st_r.mode),
    .code(st_r.stage[`AKC_CODE_MSB:`AKC_CODE_LSB]),
    .kind(kind),
    .unused(unused)
  );

  // Read multiplexer; unmapped offsets read as zero
  always_comb begin
    rd_word = `AKC_RST_WORD;
    case (avs_address)
      `AKC_OFF_CTRL: rd_word[`AKC_MODE_BIT] = st_r.mode;
      `AKC_OFF_STAGE: rd_word[7:0] = st_r.stage;
      `AKC_OFF_CODE: rd_word[3:0] =
        st_r.stage[`AKC_CODE_MSB:`AKC_CODE_LSB];
      `AKC_OFF_NODE: rd_word[3:0] =
        st_r.stage[`AKC_NODE_MSB:`AKC_NODE_LSB];
      `AKC_OFF_TX: rd_word[7:0] = st_r.tx;
      `AKC_OFF_STATUS: begin
        rd_word[`AKC_ST_KIND_MSB:0] = kind;
        rd_word[`AKC_ST_UNUSED_POS] = unused;
        rd_word[`AKC_ST_MODE_POS] = st_r.mode;
      end
      default: rd_word = `AKC_RST_WORD;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    st_nxt = st_r;
    // One cycle of waitrequest low per request, then high again
    st_nxt.wait_rq = ~((avs_read | avs_write) & st_r.wait_rq);
    if (rd_take)
      st_nxt.rdata = rd_word;
    // Mode write touches only the mode; stored bits stay as they are
    if (wr_ok && hit(avs_address, `AKC_OFF_CTRL))
      st_nxt.mode = avs_writedata[`AKC_MODE_BIT];
    st_nxt.stage = stage_edit;
    // Only the commit copies the staged byte to the line
    if (wr_ok && hit(avs_address, `AKC_OFF_COMMIT))
      st_nxt.tx = st_r.stage;
    // Frame slot carries the committed byte
    st_nxt.oh_valid = oh_slot;
    if (oh_slot)
      st_nxt.oh_data = st_r.tx;
  end

  // State register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r.mode <= `AKC_RST_MODE;
      st_r.stage <= `AKC_RST_STAGE;
      st_r.tx <= `AKC_RST_TX;
      st_r.wait_rq <= 1'b1;
      st_r.rdata <= `AKC_RST_WORD;
      st_r.oh_data <= `AKC_RST_TX;
      st_r.oh_valid <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata = st_r.rdata;
  assign avs_waitrequest = st_r.wait_rq;
  assign oh_k1_data = st_r.oh_data;
  assign oh_k1_valid = st_r.oh_valid;
  assign tx_byte = st_r.tx;
  assign mode_ring = st_r.mode;

  // Checks on the running design
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_taken(logic [5:0] off);
    wr_ok && avs_address == off;
  endsequence

  sequence s_commit_then_slot;
    s_taken(`AKC_OFF_COMMIT) ##1 oh_slot;
  endsequence

  sequence s_request_waiting;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  chk_wait_answer: assert property (
    s_request_waiting |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest did not answer in one cycle");

  chk_read_data: assert property (
    avs_read && avs_waitrequest && avs_address == `AKC_OFF_TX
    |=> avs_readdata[7:0] == $past(tx_byte))
    else $error("read of transmitted byte returned wrong data");

  chk_commit_copy: assert property (
    s_taken(`AKC_OFF_COMMIT) |=> tx_byte == $past(st_r.stage))
    else $error("commit did not copy the staged byte");

  chk_edit_holds_tx: assert property (
    !(wr_ok && avs_address == `AKC_OFF_COMMIT) |=> $stable(tx_byte))
    else $error("transmitted byte changed without a commit");

  chk_frame_slot: assert property (
    s_commit_then_slot |=> oh_k1_valid
      && oh_k1_data == $past(st_r.stage, 2))
    else $error("frame slot did not carry the committed byte");

  chk_slot_only: assert property (
    !oh_slot |=> !oh_k1_valid)
    else $error("byte strobe without a frame slot");

  chk_mode_keeps: assert property (
    s_taken(`AKC_OFF_CTRL) |=> $stable(st_r.stage)
      && mode_ring == $past(avs_writedata[`AKC_MODE_BIT]))
    else $error("mode change altered the stored bits");

  chk_span_unused: assert property (
    !mode_ring && st_r.stage[7:4] inside {4'h3, 4'h5, 4'h7, 4'h9}
    |-> unused)
    else $error("unused span code not flagged");

  chk_ring_used: assert property (
    mode_ring |-> !unused && kind != RQ_NO_REVERT)
    else $error("ring code decoded as unused");

  chk_span_table: assert property (
    !mode_ring && st_r.stage[7:4] == 4'hB |-> kind == RQ_DEG_HI)
    else $error("span high priority degrade decoded wrongly");

  chk_ring_table: assert property (
    mode_ring && st_r.stage[7:4] == 4'hA |-> kind == RQ_DEG_PROT)
    else $error("ring protection degrade decoded wrongly");

  chk_preset_alt: assert property (
    s_taken(`AKC_OFF_PRESET)
      && avs_writedata[1:0] == `AKC_SEL_ALT
    |=> st_r.stage == `AKC_PAT_ALT)
    else $error("alternating preset not loaded");

  chk_bit_msb: assert property (
    s_taken(`AKC_OFF_BIT) && avs_writedata[3:0] == 4'h1
    |=> st_r.stage[7] == $past(avs_writedata[7])
      && st_r.stage[6:0] == $past(st_r.stage[6:0]))
    else $error("bit one did not land in the top position");

  chk_node_field: assert property (
    s_taken(`AKC_OFF_NODE)
    |=> st_r.stage[3:0] == $past(avs_writedata[3:0])
      && $stable(st_r.stage[7:4]))
    else $error("node field write wrong");

  chk_code_field: assert property (
    s_taken(`AKC_OFF_CODE)
    |=> st_r.stage[7:4] == $past(avs_writedata[3:0])
      && $stable(st_r.stage[3:0]))
    else $error("request code write wrong");

  // Read answers: the word captured while waitrequest was high
  sequence s_read_at(logic [5:0] off);
    avs_read && avs_waitrequest && avs_address == off;
  endsequence

  chk_read_stage: assert property (
    s_read_at(`AKC_OFF_STAGE)
    |=> avs_readdata == {24'h000000, $past(st_r.stage)})
    else $error("read of staged byte returned wrong data");

  chk_read_mode: assert property (
    s_read_at(`AKC_OFF_CTRL)
    |=> avs_readdata == {31'h00000000, $past(mode_ring)})
    else $error("read of mode returned wrong data");

  chk_read_code: assert property (
    s_read_at(`AKC_OFF_CODE)
    |=> avs_readdata == {28'h0000000, $past(st_r.stage[7:4])})
    else $error("read of request code returned wrong data");

  chk_whole_load: assert property (
    s_taken(`AKC_OFF_STAGE)
    |=> st_r.stage == $past(avs_writedata[7:0]))
    else $error("whole byte write not loaded");

  chk_preset_zeros: assert property (
    s_taken(`AKC_OFF_PRESET)
      && avs_writedata[1:0] == `AKC_SEL_ZEROS
    |=> st_r.stage == `AKC_PAT_ZEROS)
    else $error("all zeros preset not loaded");

  chk_preset_ones: assert property (
    s_taken(`AKC_OFF_PRESET)
      && avs_writedata[1:0] == `AKC_SEL_ONES
    |=> st_r.stage == `AKC_PAT_ONES)
    else $error("all ones preset not loaded");

  // Selector three is spare and must leave the staged byte alone
  chk_preset_spare: assert property (
    s_taken(`AKC_OFF_PRESET) && avs_writedata[1:0] == 2'h3
    |=> $stable(st_r.stage))
    else $error("spare preset selector changed the byte");

  chk_bit_range: assert property (
    s_taken(`AKC_OFF_BIT)
      && (avs_writedata[3:0] < `AKC_BIT_FIRST
        || avs_writedata[3:0] > `AKC_BIT_LAST)
    |=> $stable(st_r.stage))
    else $error("out of range bit number changed the byte");

  // A write on a disabled lane is answered but must change nothing
  chk_lane_off: assert property (
    avs_write && !avs_waitrequest && !avs_byteenable[0]
    |=> $stable(st_r.stage) && $stable(tx_byte) && $stable(mode_ring))
    else $error("write with lane zero off changed state");

  chk_slot_data: assert property (
    oh_slot |=> oh_k1_valid && oh_k1_data == $past(tx_byte))
    else $error("frame slot did not carry the transmitted byte");

  chk_data_holds: assert property (
    !oh_slot |=> $stable(oh_k1_data))
    else $error("frame byte changed outside a slot");

  chk_ring_revert: assert property (
    mode_ring && st_r.stage[7:4] == 4'h1 |-> kind == RQ_REV_RING)
    else $error("ring reverse request decoded wrongly");

  chk_span_wait: assert property (
    !mode_ring && st_r.stage[7:4] == 4'h6 |-> kind == RQ_RESTORE_WAIT)
    else $error("span wait to restore decoded wrongly");

endmodule : akc_composer

// ---- akc_composer_tb_top.sv ----
// Self-checking bench for the request byte composer.
// Assumes akc_pkg, akc_params.svh and akc_frame_model compiled first.
`timescale 1ns/1ns
`include "akc_params.svh"

module akc_composer_tb_top
  import akc_pkg::*;
();
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hF;
  logic burst = 1'b0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, oh_slot, oh_k1_valid, mode_ring, late_err;
  logic [7:0] oh_k1_data, tx_byte, rx_byte, rx_cnt;
  int errors = 0;
  int n_compared = 0;
  // Span meanings; ring meanings follow the code value itself
  akc_req_e span_tab [16] = '{RQ_NONE, RQ_NO_REVERT, RQ_REVERSE,
    RQ_UNUSED, RQ_EXER, RQ_UNUSED, RQ_RESTORE_WAIT, RQ_UNUSED, RQ_MANUAL,
    RQ_UNUSED, RQ_DEG_LO, RQ_DEG_HI, RQ_FAIL_LO, RQ_FAIL_HI, RQ_FORCE,
    RQ_LOCKOUT};
  logic [7:0] pre [4] = '{8'h00, 8'hFF, 8'hAA, 8'h3C};

  always #20 mclk = ~mclk;

  akc_composer i_dut (.mclk, .arst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .oh_slot, .oh_k1_data, .oh_k1_valid, .tx_byte, .mode_ring);
  akc_frame_model i_far (.mclk, .arst_n, .burst, .oh_k1_data,
    .oh_k1_valid, .oh_slot, .rx_byte, .rx_cnt, .late_err);

  task automatic report_and_stop;
    if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // One Avalon access; waitrequest is looked at on each rising edge,
  // before that edge updates it, and read data are taken there too
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      errors++;
      report_and_stop();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  // Waits for two caught frame bytes, bounded
  task automatic frames;
    logic [7:0] c;
    int n;
    c = rx_cnt;
    n = 0;
    while (8'(rx_cnt - c) < 8'h02 && n < 60) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 60) begin
      errors++;
      report_and_stop();
    end
  endtask : frames

  task automatic t_reset;
    bus(1'b0, `AKC_OFF_STAGE, 32'h0);
    cmp(q, 32'h000000AA);
    bus(1'b0, `AKC_OFF_TX, 32'h0);
    cmp(q, 32'h00000000);
    cmp({31'h0, mode_ring}, 32'h0);
  endtask : t_reset

  // Every code in both modes, with a varying lower nibble
  task automatic t_codes;
    logic [4:0] k;
    logic un;
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, `AKC_OFF_CTRL, 32'(m));
      @(negedge mclk);
      cmp({31'h0, mode_ring}, 32'(m));
      bus(1'b0, `AKC_OFF_CTRL, 32'h0);
      cmp(q, 32'(m));
      for (int c = 0; c < 16; c++) begin
        bus(1'b1, `AKC_OFF_CODE, 32'(c));
        bus(1'b1, `AKC_OFF_NODE, 32'(15 - c));
        bus(1'b0, `AKC_OFF_STAGE, 32'h0);
        cmp(q, 32'(c * 16 + 15 - c));
        bus(1'b0, `AKC_OFF_CODE, 32'h0);
        cmp(q, 32'(c));
        bus(1'b0, `AKC_OFF_NODE, 32'h0);
        cmp(q, 32'(15 - c));
        k = (m == 1) ? 5'(c) : span_tab[c];
        un = (m == 0) && (c inside {3, 5, 7, 9});
        bus(1'b0, `AKC_OFF_STATUS, 32'h0);
        cmp(q, {25'h0, m[0], un, k});
      end
    end
  endtask : t_codes

  task automatic t_edits;
    logic [7:0] e;
    bus(1'b1, `AKC_OFF_STAGE, 32'h5A);
    bus(1'b1, `AKC_OFF_CTRL, 32'h0);
    bus(1'b0, `AKC_OFF_STAGE, 32'h0);
    cmp(q, 32'h0000005A);
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, `AKC_OFF_STAGE, 32'h3C);
      bus(1'b1, `AKC_OFF_PRESET, 32'(p));
      bus(1'b0, `AKC_OFF_STAGE, 32'h0);
      cmp(q, {24'h0, pre[p]});
    end
    e = 8'h3C;
    for (int n = 0; n < 10; n++) begin
      bus(1'b1, `AKC_OFF_BIT, {24'h0, n[0], 3'h0, n[3:0]});
      if (n >= 1 && n <= 8) e[8 - n] = n[0];
      bus(1'b0, `AKC_OFF_STAGE, 32'h0);
      cmp(q, {24'h0, e});
    end
    // Disabled lane and read-only place change nothing; an unmapped place reads zero
    avs_byteenable <= 4'h0;
    bus(1'b1, `AKC_OFF_STAGE, 32'h11);
    avs_byteenable <= 4'hF;
    bus(1'b1, `AKC_OFF_TX, 32'h22);
    bus(1'b0, `AKC_OFF_STAGE, 32'h0);
    cmp(q, {24'h0, e});
    bus(1'b0, 6'h24, 32'h0);
    cmp(q, 32'h00000000);
  endtask : t_edits

  task automatic t_commit;
    frames();
    cmp({24'h0, rx_byte}, 32'h0);
    bus(1'b1, `AKC_OFF_STAGE, 32'hC3);
    bus(1'b1, `AKC_OFF_COMMIT, 32'h1);
    bus(1'b1, `AKC_OFF_STAGE, 32'h96);
    frames();
    cmp({24'h0, tx_byte}, 32'hC3);
    cmp({24'h0, rx_byte}, 32'hC3);
    burst <= 1'b1;
    bus(1'b1, `AKC_OFF_COMMIT, 32'h1);
    // Back-to-back slots carry the newly committed byte after four more caught bytes
    frames();
    frames();
    burst <= 1'b0;
    cmp({24'h0, rx_byte}, 32'h96);
    bus(1'b0, `AKC_OFF_TX, 32'h0);
    cmp(q, 32'h00000096);
    cmp({31'h0, late_err}, 32'h0);
  endtask : t_commit

  initial begin
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    t_codes();
    t_edits();
    t_commit();
    report_and_stop();
  end
endmodule : akc_composer_tb_top

// ---- akc_frame_model.sv ----
// Far side model: overhead inserter slots and a byte catcher.
// Assumes the composer answers each slot one cycle later on mclk.
`timescale 1ns/1ns

module akc_frame_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic burst,
  input wire logic [7:0] oh_k1_data,
  input wire logic oh_k1_valid,
  output logic oh_slot,
  output logic [7:0] rx_byte,
  output logic [7:0] rx_cnt,
  output logic late_err
);
  logic [2:0] gap_r;
  logic slot_d_r;
  // Slot every eighth cycle, or every cycle in burst to stress spacing
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gap_r <= 3'h0;
      oh_slot <= 1'b0;
      slot_d_r <= 1'b0;
      rx_byte <= 8'h00;
      rx_cnt <= 8'h00;
      late_err <= 1'b0;
    end else begin
      gap_r <= gap_r + 3'h1;
      oh_slot <= burst || (gap_r == 3'h7);
      slot_d_r <= oh_slot;
      if (oh_k1_valid != slot_d_r) late_err <= 1'b1;
      if (oh_k1_valid) begin
        rx_byte <= oh_k1_data;
        rx_cnt <= rx_cnt + 8'h01;
      end
    end
  end
endmodule : akc_frame_model

// ---- akc_params.svh ----
// Constants of the request byte composer: offsets, fields, patterns.
// Defines only; included by the editor, table, composer top and bench top files.
`ifndef AKC_PARAMS_SVH
`define AKC_PARAMS_SVH

// Byte offsets of the register map on the Avalon slave
`define AKC_OFF_CTRL 6'h00
`define AKC_OFF_STAGE 6'h04
`define AKC_OFF_CODE 6'h08
`define AKC_OFF_NODE 6'h0C
`define AKC_OFF_PRESET 6'h10
`define AKC_OFF_BIT 6'h14
`define AKC_OFF_COMMIT 6'h18
`define AKC_OFF_TX 6'h1C
`define AKC_OFF_STATUS 6'h20

// Field positions in the byte and in the write data
`define AKC_MODE_BIT 0
`define AKC_CODE_MSB 7
`define AKC_CODE_LSB 4
`define AKC_NODE_MSB 3
`define AKC_NODE_LSB 0
`define AKC_BITVAL_POS 7
`define AKC_PRESET_MSB 1
`define AKC_ST_KIND_MSB 4
`define AKC_ST_UNUSED_POS 5
`define AKC_ST_MODE_POS 6

// Mode encoding, preset selectors and patterns
`define AKC_MODE_SPAN 1'b0
`define AKC_MODE_RING 1'b1
`define AKC_SEL_ZEROS 2'h0
`define AKC_SEL_ONES 2'h1
`define AKC_SEL_ALT 2'h2
`define AKC_PAT_ZEROS 8'h00
`define AKC_PAT_ONES 8'hFF
`define AKC_PAT_ALT 8'hAA
`define AKC_BIT_FIRST 4'h1
`define AKC_BIT_LAST 4'h8

// Reset values
`define AKC_RST_STAGE 8'hAA
`define AKC_RST_TX 8'h00
`define AKC_RST_MODE 1'b0
`define AKC_RST_WORD 32'h00000000

`endif

// ---- akc_pkg.sv ----
// Types shared by the request byte composer modules.
// Assumes akc_params.svh is compiled alongside; holds no logic.
package akc_pkg;

  // Meaning of the request code under the selected mode
  typedef enum logic [4:0] {
    RQ_NONE, RQ_REV_RING, RQ_REV_SPAN, RQ_EXER_RING, RQ_EXER_SPAN,
    RQ_RESTORE_WAIT, RQ_MAN_RING, RQ_MAN_SPAN, RQ_DEG_RING, RQ_DEG_SPAN,
    RQ_DEG_PROT, RQ_FAIL_RING, RQ_FAIL_SPAN, RQ_FORCE_RING, RQ_FORCE_SPAN,
    RQ_LOCK_SPAN, RQ_NO_REVERT, RQ_REVERSE, RQ_EXER, RQ_MANUAL,
    RQ_DEG_LO, RQ_DEG_HI, RQ_FAIL_LO, RQ_FAIL_HI, RQ_FORCE, RQ_LOCKOUT,
    RQ_UNUSED
  } akc_req_e;

  // Edit applied to the staged byte
  typedef enum logic [2:0] {
    OP_NONE, OP_WHOLE, OP_CODE, OP_NODE, OP_PRESET, OP_BIT
  } akc_op_e;

  // Whole state of the composer top
  typedef struct packed {
    logic mode;
    logic [7:0] stage;
    logic [7:0] tx;
    logic wait_rq;
    logic [31:0] rdata;
    logic [7:0] oh_data;
    logic oh_valid;
  } akc_state_s;

endpackage : akc_pkg
